// ---- src/pab_port.sv ----
// Eight-bit bidirectional port with direction, latch and pin read.
// Assumes an AXI4-Lite master and pins resolved by the testbench.
`timescale 1ns/1ps
module pab_port
   import pab_pkg::*;
#(
   parameter int WIDTH = PAB_WIDTH
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // AXI4-Lite write
   input wire logic [PAB_ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // AXI4-Lite read
   input wire logic [PAB_ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe_out,
   // Shared functions
   input wire logic [1:0] osc_mode_in,
   input wire logic [WIDTH-1:0] analog_en_in,
   input wire logic ser_tx_in,
   input wire logic ser_tx_oe_in,
   output logic ser_rx_out,
   output logic pwm_fault_input_n_out,
   output logic master_reset_input_n_out
);

   // ********************************
   // Pin synchroniser
   // ********************************
   logic [WIDTH-1:0] sync1_q, sync2_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // ********************************
   // Pin ownership
   // ********************************
   logic [7:0] cfg_q, cfg_d;
   logic [WIDTH-1:0] lat_q, lat_d, dir_q, dir_d;
   logic [WIDTH-1:0] io_en, in_en, pin_read;
   logic [WIDTH-1:0] pin_d, oe_d;
   logic rx_d, flt_d, mrst_d;
   pab_osc_t osc;
   logic ref_on, tx_on, rx_on;

   always_comb begin
      osc = pab_osc_t'(osc_mode_in);
      ref_on = cfg_q[PAB_CFG_REF_EN];
      tx_on = cfg_q[PAB_CFG_SER_TX];
      rx_on = cfg_q[PAB_CFG_SER_RX];
      io_en = '1;
      // Bit six free in io modes; any external oscillator claims bit seven
      io_en[PAB_BIT_OSC2] = (osc != PAB_OSC_EXT_XTAL);
      io_en[PAB_BIT_OSC1] = (osc == PAB_OSC_INT_IO);
      if (ref_on) begin
         io_en[PAB_BIT_REF] = 1'b0;
      end
      in_en = io_en & ~analog_en_in;
      pin_read = sync2_q & in_en;
      // Direction one releases the driver, also in analog use
      oe_d = ~dir_q & io_en;
      oe_d[PAB_BIT_RST] = 1'b0;
      pin_d = lat_q & oe_d;
      // Serial takes its pins when enabled, except bit two while the reference is on
      if (tx_on) begin
         pin_d[PAB_BIT_REF] = ser_tx_in;
         oe_d[PAB_BIT_REF] = ser_tx_oe_in && !ref_on;
      end
      if (rx_on) begin
         oe_d[PAB_BIT_SRX] = 1'b0;
         pin_d[PAB_BIT_SRX] = 1'b0;
      end
      rx_d = rx_on ? sync2_q[PAB_BIT_SRX] : 1'b1;
      flt_d = cfg_q[PAB_CFG_FLT_SEL] ? sync2_q[PAB_BIT_OSC1]
                                     : sync2_q[PAB_BIT_RST];
      mrst_d = sync2_q[PAB_BIT_RST];
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_out <= '0;
         pin_oe_out <= '0;
         ser_rx_out <= 1'b1;
         pwm_fault_input_n_out <= 1'b1;
         master_reset_input_n_out <= 1'b1;
      end else begin
         pin_out <= pin_d;
         pin_oe_out <= oe_d;
         ser_rx_out <= rx_d;
         pwm_fault_input_n_out <= flt_d;
         master_reset_input_n_out <= mrst_d;
      end
   end

   // ********************************
   // AXI4-Lite slave
   // ********************************
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [PAB_ADDR_W-1:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic bad_w_q, bad_w_d;
   logic [1:0] rr_q, rr_d;
   // Write response held in a flop, so unmapped writes also report an error
   logic [1:0] br_q, br_d;
   logic do_wr;

   function automatic logic mapped(input logic [PAB_ADDR_W-1:0] a);
      mapped = (a == PAB_OFF_PIN) || (a == PAB_OFF_LAT) ||
               (a == PAB_OFF_DIR) || (a == PAB_OFF_CFG);
   endfunction

   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      bv_d = bv_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      bad_w_d = bad_w_q;
      br_d = br_q;
      lat_d = lat_q;
      dir_d = dir_q;
      cfg_d = cfg_q;
      do_wr = 1'b0;
      if (s_axi_awvalid_in && !aw_q && !bv_q) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_q && !bv_q) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata_in;
         if (!s_axi_wstrb_in[0]) begin
            wd_d = {24'h000000, 8'h00};
         end
         bad_w_d = !s_axi_wstrb_in[0];
      end
      if (aw_q && w_q) begin
         do_wr = 1'b1;
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = (mapped(awa_q) && !bad_w_q) ? PAB_RESP_OKAY : PAB_RESP_SLVERR;
         if (mapped(awa_q) && !bad_w_q) begin
            case (awa_q)
               PAB_OFF_PIN, PAB_OFF_LAT: begin
                  lat_d = wd_q[WIDTH-1:0];
               end
               PAB_OFF_DIR: begin
                  dir_d = wd_q[WIDTH-1:0];
               end
               PAB_OFF_CFG: begin
                  cfg_d = wd_q[7:0];
               end
               default: begin
                  cfg_d = cfg_q;
               end
            endcase
         end
      end
      if (bv_q && s_axi_bready_in) begin
         bv_d = 1'b0;
      end
      if (rv_q && s_axi_rready_in) begin
         rv_d = 1'b0;
      end else if (s_axi_arvalid_in && !rv_q) begin
         rv_d = 1'b1;
         rr_d = mapped(s_axi_araddr_in) ? PAB_RESP_OKAY : PAB_RESP_SLVERR;
         case (s_axi_araddr_in)
            PAB_OFF_PIN: rd_d = {24'h000000, pin_read};
            PAB_OFF_LAT: rd_d = {24'h000000, lat_q & io_en};
            PAB_OFF_DIR: rd_d = {24'h000000, dir_q & io_en};
            PAB_OFF_CFG: rd_d = {24'h000000, cfg_q};
            default: rd_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bv_q <= 1'b0;
         rv_q <= 1'b0;
         awa_q <= '0;
         wd_q <= '0;
         rd_q <= '0;
         rr_q <= PAB_RESP_OKAY;
         br_q <= PAB_RESP_OKAY;
         bad_w_q <= 1'b0;
         lat_q <= PAB_LAT_RST;
         dir_q <= PAB_DIR_RST;
         cfg_q <= PAB_CFG_RST;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         bv_q <= bv_d;
         rv_q <= rv_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         br_q <= br_d;
         bad_w_q <= bad_w_d;
         lat_q <= lat_d;
         dir_q <= dir_d;
         cfg_q <= cfg_d;
      end
   end

   // Ready only while the slot is empty, so outputs stay registered
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_arready_out <= 1'b0;
      end else begin
         s_axi_awready_out <= !aw_d && !bv_d && !(s_axi_awvalid_in && !aw_q && !bv_q);
         s_axi_wready_out <= !w_d && !bv_d && !(s_axi_wvalid_in && !w_q && !bv_q);
         s_axi_arready_out <= !rv_d;
      end
   end
   assign s_axi_bvalid_out = bv_q;
   assign s_axi_bresp_out = br_q;
   assign s_axi_rvalid_out = rv_q;
   assign s_axi_rdata_out = rd_q;
   assign s_axi_rresp_out = rr_q;

   // ********************************
   // Checks
   // ********************************
   a_input_released: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (dir_q == PAB_DIR_RST && !tx_on) |=> (pin_oe_out == '0))
      else $error("pin driven while all directions are input");
   a_output_drives_latch: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!dir_q[0] && !ref_on) |=> (pin_oe_out[0] && pin_out[0] == $past(lat_q[0])))
      else $error("output pin does not follow latch");
   a_reset_input_only: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !pin_oe_out[PAB_BIT_RST])
      else $error("reset pin driven");
   a_analog_reads_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
      |(pin_read & analog_en_in) == 1'b0)
      else $error("analog pin visible in read");
   a_xtal_top_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (osc == PAB_OSC_EXT_XTAL) |=> !pin_oe_out[PAB_BIT_OSC1] && !pin_oe_out[PAB_BIT_OSC2])
      else $error("oscillator pins driven");
   a_osc1_claimed: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (osc != PAB_OSC_INT_IO) |=> !pin_oe_out[PAB_BIT_OSC1])
      else $error("bit seven driven while oscillator owns it");
   a_ref_blocks_bit2: assert property (@(posedge clk_in) disable iff (!nrst_in)
      ref_on |=> !pin_oe_out[PAB_BIT_REF])
      else $error("reference pin driven");
   a_fault_select: assert property (@(posedge clk_in) disable iff (!nrst_in)
      cfg_q[PAB_CFG_FLT_SEL] ##1 cfg_q[PAB_CFG_FLT_SEL]
      |-> pwm_fault_input_n_out == $past(sync2_q[PAB_BIT_OSC1]))
      else $error("fault input from wrong pin");
   a_pin_sync_two: assert property (@(posedge clk_in) disable iff (!nrst_in)
      $past(sync1_q) == sync2_q)
      else $error("pin read skips synchroniser");
endmodule

// ---- pkg/pab_pkg.sv ----
// Constants for the eight-bit bidirectional port block.
// Assumes an AXI4-Lite register bus with 32-bit data.
package pab_pkg;
   localparam int PAB_WIDTH = 8;
   localparam int PAB_ADDR_W = 4;
   // Register byte addresses
   localparam logic [3:0] PAB_OFF_PIN = 4'h0;
   localparam logic [3:0] PAB_OFF_LAT = 4'h4;
   localparam logic [3:0] PAB_OFF_DIR = 4'h8;
   localparam logic [3:0] PAB_OFF_CFG = 4'hC;
   // Reset values
   localparam logic [7:0] PAB_LAT_RST = 8'h00;
   localparam logic [7:0] PAB_DIR_RST = 8'hFF;
   localparam logic [7:0] PAB_ANA_RST = 8'h33;
   localparam logic [7:0] PAB_CFG_RST = 8'h00;
   // Config register fields
   localparam int PAB_CFG_OSC_LSB = 0;
   localparam int PAB_CFG_FLT_SEL = 2;
   localparam int PAB_CFG_REF_EN = 3;
   localparam int PAB_CFG_SER_TX = 4;
   localparam int PAB_CFG_SER_RX = 5;
   // Pin indices
   localparam int PAB_BIT_REF = 2;
   localparam int PAB_BIT_SRX = 3;
   localparam int PAB_BIT_RST = 5;
   localparam int PAB_BIT_OSC2 = 6;
   localparam int PAB_BIT_OSC1 = 7;
   // AXI responses
   localparam logic [1:0] PAB_RESP_OKAY = 2'h0;
   localparam logic [1:0] PAB_RESP_SLVERR = 2'h2;
   // Oscillator modes
   typedef enum logic [1:0] {
      PAB_OSC_EXT_XTAL = 2'h0,
      PAB_OSC_RC_IO = 2'h1,
      PAB_OSC_INT_IO = 2'h3,
      PAB_OSC_EXT_CLK_IO = 2'h2
   } pab_osc_t;
endpackage

// ---- dv/pab_board.sv ----
// Board-side model of the eight port pins and their outside drivers.
// Assumes the bench sets the outside drive values and their enables.
`timescale 1ns/1ps
module pab_board (
   // Design side
   input wire logic [7:0] pin_out_in,
   input wire logic [7:0] pin_oe_in,
   // Board side
   input wire logic [7:0] ext_val_in,
   input wire logic [7:0] ext_en_in,
   output logic [7:0] pin_lvl_out
);
   // Undriven pins float high through board pull-ups
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe_in[i]) begin
            pin_lvl_out[i] = pin_out_in[i];
         end else if (ext_en_in[i]) begin
            pin_lvl_out[i] = ext_val_in[i];
         end else begin
            pin_lvl_out[i] = 1'h1;
         end
      end
   end
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the port block over AXI4-Lite.
// Assumes the board model resolves pins; no other agents on the bus.
`timescale 1ns/1ps
module testbench;
   import pab_pkg::*;
   logic clk_in, nrst_in, awv, wv, bre, arv, rre, tx, txoe;
   logic awr, wrd, bv, arr, rv, rx, flt_n, mr_n;
   logic [3:0] awa, ara, wst;
   logic [31:0] wd, rdat;
   logic [1:0] br, rr, osc;
   logic [7:0] po, poe, lvl, ana, ev, een;
   int failures, tests_run, cyc;

   pab_port pab_port_i (.clk_in(clk_in), .nrst_in(nrst_in), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(wst), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rre), .pin_in(lvl), .pin_out(po), .pin_oe_out(poe),
      .osc_mode_in(osc), .analog_en_in(ana), .ser_tx_in(tx), .ser_tx_oe_in(txoe),
      .ser_rx_out(rx), .pwm_fault_input_n_out(flt_n), .master_reset_input_n_out(mr_n));
   pab_board pab_board_i (.pin_out_in(po), .pin_oe_in(poe), .ext_val_in(ev),
      .ext_en_in(een), .pin_lvl_out(lvl));

   // ****************
   // Bus tasks
   // ****************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      @(posedge clk_in);
      awa <= a;
      wd <= {24'h0, d};
      wst <= s;
      awv <= 1'h1;
      wv <= 1'h1;
      bre <= 1'h1;
      do begin
         @(posedge clk_in);
         if (awv && awr) awv <= 1'h0;
         if (wv && wrd) wv <= 1'h0;
      end while (bv !== 1'h1);
      bre <= 1'h0;
      chk({30'h0, br}, {30'h0, er});
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge clk_in);
      ara <= a;
      arv <= 1'h1;
      rre <= 1'h1;
      do begin
         @(posedge clk_in);
         if (arv && arr) arv <= 1'h0;
      end while (rv !== 1'h1);
      rre <= 1'h0;
      chk(rdat, {24'h0, e});
      chk({30'h0, rr}, {30'h0, er});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic fin(input string s);
      $display("test %s ended", s);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      clk_in = 1'h0;
      forever #50 clk_in = ~clk_in;
   end
   // Whole run is well under a thousand cycles
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         test_done();
      end
   end

   // ****************
   // Tests
   // ****************
   initial begin
      {nrst_in, awv, wv, bre, arv, rre, tx, txoe, awa, ara, wst, wd} = '0;
      {osc, ana, ev, een} = {2'h3, 8'h33, 8'hFF, 8'hFF};
      wt(5);
      nrst_in <= 1'h1;
      rdc(PAB_OFF_LAT, 8'h00, PAB_RESP_OKAY);
      rdc(PAB_OFF_DIR, 8'hFF, PAB_RESP_OKAY);
      rdc(PAB_OFF_PIN, 8'hCC, PAB_RESP_OKAY);
      chk({24'h0, poe}, 32'h0);
      fin("reset");
      wr(PAB_OFF_PIN, 8'hA5, 4'hF, PAB_RESP_OKAY);
      rdc(PAB_OFF_LAT, 8'hA5, PAB_RESP_OKAY);
      wr(PAB_OFF_DIR, 8'h00, 4'hF, PAB_RESP_OKAY);
      wt(2);
      chk({24'h0, poe}, 32'hDF);
      chk({24'h0, po & poe}, 32'h85);
      ana <= 8'h00;
      wr(PAB_OFF_CFG, 8'h08, 4'hF, PAB_RESP_OKAY);
      wt(5);
      chk({24'h0, poe}, 32'hDB);
      rdc(PAB_OFF_PIN, 8'hA1, PAB_RESP_OKAY);
      wr(PAB_OFF_CFG, 8'h00, 4'hF, PAB_RESP_OKAY);
      wr(PAB_OFF_DIR, 8'hFF, 4'hF, PAB_RESP_OKAY);
      fin("output");
      ev <= 8'h5A;
      wt(5);
      rdc(PAB_OFF_PIN, 8'h5A, PAB_RESP_OKAY);
      ana <= 8'h33;
      wt(5);
      rdc(PAB_OFF_PIN, 8'h48, PAB_RESP_OKAY);
      ana <= 8'h00;
      ev <= 8'hFF;
      wr(PAB_OFF_LAT, 8'hFF, 4'hF, PAB_RESP_OKAY);
      fin("input");
      for (int m = 0; m < 4; m++) begin
         osc <= m[1:0];
         wt(5);
         rdc(PAB_OFF_LAT, {m == 3, m != 0, 6'h3F}, PAB_RESP_OKAY);
         rdc(PAB_OFF_DIR, {m == 3, m != 0, 6'h3F}, PAB_RESP_OKAY);
         rdc(PAB_OFF_PIN, {m == 3, m != 0, 6'h3F}, PAB_RESP_OKAY);
      end
      osc <= 2'h3;
      fin("oscillator");
      wr(4'h6, 8'h11, 4'hF, PAB_RESP_SLVERR);
      rdc(4'h6, 8'h00, PAB_RESP_SLVERR);
      wr(PAB_OFF_LAT, 8'h00, 4'h0, PAB_RESP_SLVERR);
      rdc(PAB_OFF_LAT, 8'hFF, PAB_RESP_OKAY);
      fin("errors");
      txoe <= 1'h1;
      wr(PAB_OFF_CFG, 8'h30, 4'hF, PAB_RESP_OKAY);
      ev <= 8'hF7;
      wt(5);
      chk({30'h0, poe[2], po[2]}, 32'h2);
      chk({31'h0, rx}, 32'h0);
      fin("serial");
      txoe <= 1'h0;
      wr(PAB_OFF_CFG, 8'h00, 4'hF, PAB_RESP_OKAY);
      ev <= 8'hDF;
      wt(5);
      chk({30'h0, mr_n, flt_n}, 32'h0);
      wr(PAB_OFF_CFG, 8'h04, 4'hF, PAB_RESP_OKAY);
      wt(5);
      chk({31'h0, flt_n}, 32'h1);
      ev <= 8'h7F;
      wt(5);
      chk({31'h0, flt_n}, 32'h0);
      fin("fault");
      test_done();
   end
endmodule
